// File: src/bridge_regs_pkg.sv
// constants shared by the bridge control and status register block
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - reading pin state returns synchronised live pin levels, not the written latch
// - writing pin state copies each bit to its pin latch; output pins follow it
// - bits 7:6 reserved, bit 5 quasi pin five, bit 4 wake pin, 3:0 programmable
// - own address kept in bits 7:1; bit 0 ignored and reads zero
// - scl rate is 7.3728 MHz divided by four times the divider value
// - time-out bit 0 enables the time-out; zero stops its count and expiry
// - 16-bit down counter on 57.6 kHz tick, loaded {bits 7:1, nine ones}
// - counter reaching zero before completion raises the time-out interrupt
// - after arbitration loss restart when bus free until the time-out expires
// - 0xF0 on completion with interrupt; reset value 0xF0 without interrupt
// - address not acknowledged gives 0xF1 and interrupt
// - data byte not acknowledged gives 0xF2 and interrupt
// - 0xF3 while busy with no interrupt; host starts nothing meanwhile
// - time-out gives 0xF8 and interrupt
// - invalid byte count gives 0xF9 and interrupt
// - interrupt released by a status read or by reset
// - command 0x20 writes one register, 0x21 reads one, no auto-increment
// - divider 0x02 reset 0x19, time-out 0x03 reset 0xFE, status 0x04, address 0x05
package bridge_regs_pkg;

	//------------------------------------------------------------------
	// register access commands and addresses
	//------------------------------------------------------------------
	localparam logic [7:0] CMD_REG_WRITE  = 8'h20;
	localparam logic [7:0] CMD_REG_READ   = 8'h21;
	localparam logic [7:0] ADDR_PIN_STATE = 8'h01;
	localparam logic [7:0] ADDR_SCL_DIV   = 8'h02;
	localparam logic [7:0] ADDR_TIMEOUT   = 8'h03;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_OWN_ADDR  = 8'h05;

	//------------------------------------------------------------------
	// reset values and field layout
	//------------------------------------------------------------------
	localparam logic [5:0] RST_PIN_LATCH  = 6'h3F;
	localparam logic [7:0] RST_SCL_DIV    = 8'h19;
	localparam logic [7:0] RST_TIMEOUT    = 8'hFE;
	localparam logic [6:0] RST_OWN_ADDR   = 7'h00;
	localparam int         PIN_COUNT      = 6;
	localparam int         PROG_PIN_COUNT = 4;
	localparam logic [8:0] TO_LOW_ONES    = 9'h1FF;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;

	// programmable pin modes, two bits per pin
	localparam logic [1:0] MODE_QUASI     = 2'h0;
	localparam logic [1:0] MODE_INPUT     = 2'h1;
	localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
	localparam logic [1:0] MODE_OPEN_DRN  = 2'h3;

	//------------------------------------------------------------------
	// result codes
	//------------------------------------------------------------------
	localparam logic [7:0] ST_DONE        = 8'hF0;
	localparam logic [7:0] ST_ADDR_NACK   = 8'hF1;
	localparam logic [7:0] ST_DATA_NACK   = 8'hF2;
	localparam logic [7:0] ST_BUSY        = 8'hF3;
	localparam logic [7:0] ST_TIMEOUT     = 8'hF8;
	localparam logic [7:0] ST_BAD_COUNT   = 8'hF9;

	//------------------------------------------------------------------
	// timing: 7.3728 MHz bridge tick made from the 200 MHz clock
	//------------------------------------------------------------------
	localparam int          CLK_HZ        = 200_000_000;
	localparam int          BRIDGE_HZ     = 7_372_800;
	localparam int          TO_TICK_HZ    = 57_600;
	localparam int          ACC_W         = 28;
	// phase accumulator step and modulus, scaled down by 100
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BRIDGE_HZ / 100);
	localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_HZ / 100);
	localparam logic [6:0]  TO_PRESCALE   = 7'(BRIDGE_HZ / TO_TICK_HZ - 1);

	// transfer watch states
	typedef enum logic [1:0]
	{
		XF_IDLE  = 2'b00,
		XF_RUN   = 2'b01,
		XF_RETRY = 2'b10
	} xfer_state_e;

endpackage : bridge_regs_pkg

// File: src/bridge_status_regs.sv
// control and status register block of an spi to i2c bridge
`timescale 1ns/1ps

module bridge_status_regs
(
	input  wire logic        clk,
	input  wire logic        nrst,
	// register commands from the spi message parser
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	// programmable pin modes from the configuration register
	input  wire logic [7:0]  prog_pin_mode,
	// io pins: quasi_pin_five, wake_quasi_pin, prog_pin_three..prog_pin_zero
	input  wire logic [5:0]  pin_in,
	output logic [5:0]       pin_out,
	output logic [5:0]       pin_oe,
	// events from the i2c master engine
	input  wire logic        xfer_start,
	input  wire logic        xfer_ok,
	input  wire logic        addr_nack,
	input  wire logic        data_nack,
	input  wire logic        arb_lost,
	input  wire logic        bus_free,
	input  wire logic        count_bad,
	// controls to the i2c master engine
	output logic [6:0]       own_addr,
	output logic             scl_quarter_tick,
	output logic             scl_phase_high,
	output logic             xfer_busy,
	output logic             restart_req,
	output logic             timeout_abort,
	// open-drain interrupt
	output logic             int_n_out,
	output logic             int_n_oe
);

	typedef struct packed
	{
		logic [5:0]                          pin_sync1;
		logic [5:0]                          pin_sync2;
		logic [5:0]                          pin_latch;
		logic [5:0]                          pin_out;
		logic [5:0]                          pin_oe;
		logic [7:0]                          scl_div;
		logic [7:0]                          timeout_cfg;
		logic [6:0]                          own_addr;
		logic [7:0]                          status;
		logic                                busy;
		logic                                irq;
		logic                                rd_valid;
		logic [7:0]                          rd_data;
		logic [bridge_regs_pkg::ACC_W-1:0]   acc;
		logic                                bridge_tick;
		logic [7:0]                          quarter_cnt;
		logic [1:0]                          scl_phase;
		logic                                quarter_tick;
		logic [6:0]                          prescale;
		logic [15:0]                         to_cnt;
		bridge_regs_pkg::xfer_state_e        xstate;
		logic                                restart_req;
		logic                                timeout_abort;
	} state_s;

	state_s state_reg;
	state_s state_next;

	//------------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------------
	always_comb
	begin
		logic        wr_hit;
		logic        rd_hit;
		logic        to_tick;
		logic        set_irq;
		logic [7:0]  set_code;
		logic        ending;
		wr_hit   = 1'b0;
		rd_hit   = 1'b0;
		to_tick  = 1'b0;
		set_irq  = 1'b0;
		set_code = bridge_regs_pkg::ST_DONE;
		ending   = 1'b0;
		state_next = state_reg;
		state_next.rd_valid      = 1'b0;
		state_next.restart_req   = 1'b0;
		state_next.timeout_abort = 1'b0;
		state_next.quarter_tick  = 1'b0;
		state_next.bridge_tick   = 1'b0;

		// two-stage synchroniser on the pin levels
		state_next.pin_sync1 = pin_in;
		state_next.pin_sync2 = state_reg.pin_sync1;

		// register commands; one register each, no address increment
		wr_hit = cmd_valid && (cmd_code == bridge_regs_pkg::CMD_REG_WRITE);
		rd_hit = cmd_valid && (cmd_code == bridge_regs_pkg::CMD_REG_READ);

		if (wr_hit)
		begin
			if (cmd_addr == bridge_regs_pkg::ADDR_PIN_STATE)
				state_next.pin_latch = cmd_wdata[5:0];
			else if (cmd_addr == bridge_regs_pkg::ADDR_SCL_DIV)
				state_next.scl_div = cmd_wdata;
			else if (cmd_addr == bridge_regs_pkg::ADDR_TIMEOUT)
				state_next.timeout_cfg = cmd_wdata;
			else if (cmd_addr == bridge_regs_pkg::ADDR_OWN_ADDR)
				state_next.own_addr = cmd_wdata[7:1];
		end

		// read data: pins give the live level, reserved bits read zero
		if (rd_hit)
		begin
			state_next.rd_valid = 1'b1;
			if (cmd_addr == bridge_regs_pkg::ADDR_PIN_STATE)
				state_next.rd_data = {2'b00, state_reg.pin_sync2};
			else if (cmd_addr == bridge_regs_pkg::ADDR_SCL_DIV)
				state_next.rd_data = state_reg.scl_div;
			else if (cmd_addr == bridge_regs_pkg::ADDR_TIMEOUT)
				state_next.rd_data = state_reg.timeout_cfg;
			else if (cmd_addr == bridge_regs_pkg::ADDR_STATUS)
				state_next.rd_data = state_reg.status;
			else if (cmd_addr == bridge_regs_pkg::ADDR_OWN_ADDR)
				state_next.rd_data = {state_reg.own_addr, 1'b0};
			else
				state_next.rd_data = bridge_regs_pkg::UNMAPPED_READ;
		end

		// 7.3728 MHz tick from the 200 MHz clock by phase accumulation
		if (state_reg.acc + bridge_regs_pkg::ACC_STEP >= bridge_regs_pkg::ACC_MOD)
		begin
			state_next.acc = state_reg.acc + bridge_regs_pkg::ACC_STEP
				- bridge_regs_pkg::ACC_MOD;
			state_next.bridge_tick = 1'b1;
		end
		else
			state_next.acc = state_reg.acc + bridge_regs_pkg::ACC_STEP;

		// scl quarter periods: divider bridge ticks each, four per scl period
		if (state_reg.bridge_tick)
		begin
			if (state_reg.quarter_cnt >= state_reg.scl_div)
			begin
				state_next.quarter_cnt  = 8'h01;
				state_next.quarter_tick = 1'b1;
				state_next.scl_phase    = state_reg.scl_phase + 2'h1;
			end
			else
				state_next.quarter_cnt = state_reg.quarter_cnt + 8'h01;
		end

		// 57.6 kHz time-out tick is the bridge tick divided by 128
		if (state_reg.bridge_tick)
		begin
			if (state_reg.prescale == bridge_regs_pkg::TO_PRESCALE)
			begin
				state_next.prescale = 7'h00;
				to_tick = 1'b1;
			end
			else
				state_next.prescale = state_reg.prescale + 7'h01;
		end

		// transfer watch: busy status, retry after arbitration loss, time-out
		case (state_reg.xstate)
			bridge_regs_pkg::XF_IDLE:
			begin
				if (count_bad)
				begin
					set_irq  = 1'b1;
					set_code = bridge_regs_pkg::ST_BAD_COUNT;
				end
				else if (xfer_start)
				begin
					state_next.xstate = bridge_regs_pkg::XF_RUN;
					state_next.status = bridge_regs_pkg::ST_BUSY;
					state_next.to_cnt = {state_reg.timeout_cfg[7:1],
						bridge_regs_pkg::TO_LOW_ONES};
				end
			end
			bridge_regs_pkg::XF_RUN, bridge_regs_pkg::XF_RETRY:
			begin
				if (state_reg.timeout_cfg[0] && to_tick)
					state_next.to_cnt = state_reg.to_cnt - 16'h0001;
				if (state_reg.timeout_cfg[0] && (state_reg.to_cnt == 16'h0000))
				begin
					// expiry beats any other event in the same cycle
					ending = 1'b1;
					state_next.timeout_abort = 1'b1;
					set_code = bridge_regs_pkg::ST_TIMEOUT;
				end
				else if (state_reg.xstate == bridge_regs_pkg::XF_RETRY)
				begin
					if (bus_free)
					begin
						state_next.restart_req = 1'b1;
						state_next.xstate = bridge_regs_pkg::XF_RUN;
					end
				end
				else if (arb_lost)
					state_next.xstate = bridge_regs_pkg::XF_RETRY;
				else if (addr_nack)
				begin
					ending = 1'b1;
					set_code = bridge_regs_pkg::ST_ADDR_NACK;
				end
				else if (data_nack)
				begin
					ending = 1'b1;
					set_code = bridge_regs_pkg::ST_DATA_NACK;
				end
				else if (xfer_ok)
				begin
					ending = 1'b1;
					set_code = bridge_regs_pkg::ST_DONE;
				end
				if (ending)
				begin
					set_irq = 1'b1;
					state_next.xstate = bridge_regs_pkg::XF_IDLE;
				end
			end
			default:
				state_next.xstate = bridge_regs_pkg::XF_IDLE;
		endcase

		if (set_irq)
			state_next.status = set_code;

		// busy has its own flop so the output needs no decode after the register
		state_next.busy = (state_next.status == bridge_regs_pkg::ST_BUSY);

		// a status read releases the line; a new result in that cycle wins
		if (set_irq)
			state_next.irq = 1'b1;
		else if (rd_hit && (cmd_addr == bridge_regs_pkg::ADDR_STATUS))
			state_next.irq = 1'b0;

		// pin drivers from the written latch
		for (int i = 0; i < bridge_regs_pkg::PIN_COUNT; i++)
		begin
			logic [1:0] mode;
			mode = bridge_regs_pkg::MODE_QUASI;
			if (i < bridge_regs_pkg::PROG_PIN_COUNT)
				mode = prog_pin_mode[2*i +: 2];
			// quasi and open-drain pull low only; the high level comes from a pull-up
			state_next.pin_out[i] = 1'b0;
			state_next.pin_oe[i]  = ~state_next.pin_latch[i];
			if (mode == bridge_regs_pkg::MODE_PUSH_PULL)
			begin
				state_next.pin_out[i] = state_next.pin_latch[i];
				state_next.pin_oe[i]  = 1'b1;
			end
			else if (mode == bridge_regs_pkg::MODE_INPUT)
				state_next.pin_oe[i] = 1'b0;
		end
	end

	//------------------------------------------------------------------
	// state register; reset gives done status with no interrupt pending
	//------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg              <= '0;
			state_reg.pin_latch    <= bridge_regs_pkg::RST_PIN_LATCH;
			state_reg.scl_div      <= bridge_regs_pkg::RST_SCL_DIV;
			state_reg.timeout_cfg  <= bridge_regs_pkg::RST_TIMEOUT;
			state_reg.own_addr     <= bridge_regs_pkg::RST_OWN_ADDR;
			state_reg.status       <= bridge_regs_pkg::ST_DONE;
			state_reg.irq          <= 1'b0;
			state_reg.quarter_cnt  <= 8'h01;
			state_reg.xstate       <= bridge_regs_pkg::XF_IDLE;
		end
		else
			state_reg <= state_next;
	end

	//------------------------------------------------------------------
	// outputs straight from flops, except int_n_out which is tied low
	//------------------------------------------------------------------
	assign rd_valid         = state_reg.rd_valid;
	assign rd_data          = state_reg.rd_data;
	assign pin_out          = state_reg.pin_out;
	assign pin_oe           = state_reg.pin_oe;
	assign own_addr         = state_reg.own_addr;
	assign scl_quarter_tick = state_reg.quarter_tick;
	assign scl_phase_high   = state_reg.scl_phase[1];
	assign xfer_busy        = state_reg.busy;
	assign restart_req      = state_reg.restart_req;
	assign timeout_abort    = state_reg.timeout_abort;
	// the request rides on the enable; a released line is pulled high outside
	assign int_n_out        = 1'b0;          // open drain: only ever pulls low
	assign int_n_oe         = state_reg.irq;

endmodule : bridge_status_regs

// File: verif/bridge_status_regs_properties.sv
// assertion checker bound to the bridge status register block
`timescale 1ns/1ps

module bridge_status_regs_checker
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic       rd_valid,
	input wire logic [7:0] prog_pin_mode,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic       xfer_start,
	input wire logic       xfer_ok,
	input wire logic       addr_nack,
	input wire logic       data_nack,
	input wire logic       arb_lost,
	input wire logic       bus_free,
	input wire logic       count_bad,
	input wire logic [6:0] own_addr,
	input wire logic       scl_quarter_tick,
	input wire logic       xfer_busy,
	input wire logic       restart_req,
	input wire logic       timeout_abort,
	input wire logic       int_n_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// decoded commands; pin check only with all programmable pins push-pull
	logic wr_cmd;
	logic rd_cmd;
	logic st_rd;
	logic own_wr;
	logic pin_wr;
	assign wr_cmd = cmd_valid && cmd_code == 8'h20;
	assign rd_cmd = cmd_valid && cmd_code == 8'h21;
	assign st_rd  = rd_cmd && cmd_addr == 8'h04;
	assign own_wr = wr_cmd && cmd_addr == 8'h05;
	assign pin_wr = wr_cmd && cmd_addr == 8'h01 && prog_pin_mode == 8'hAA;

	// register port answers and side effects
	a_read_answer: assert property (rd_cmd |=> rd_valid)
		else $error("read not answered");
	a_irq_release: assert property (st_rd && !xfer_busy && !count_bad |=> !int_n_oe)
		else $error("interrupt kept after status read");
	a_own_addr: assert property (own_wr |=> {own_addr, 1'b0} == ($past(cmd_wdata) & 8'hFE))
		else $error("own address not taken");
	a_pin_drive: assert property (pin_wr |=> {2'b00, pin_out} == ($past(cmd_wdata) & 8'h0F))
		else $error("pin drive wrong");
	a_pin_enable: assert property (pin_wr |=> {2'b00, pin_oe} == ((~$past(cmd_wdata) & 8'h30) | 8'h0F))
		else $error("pin enable wrong");

	// transfer results; a result outside a retry and without arbitration loss ends busy and raises the interrupt
	a_done_irq: assert property (xfer_busy && xfer_ok && !arb_lost |=> int_n_oe && !xfer_busy)
		else $error("completion not reported");
	a_addr_nack: assert property (xfer_busy && addr_nack && !arb_lost |=> int_n_oe)
		else $error("address nack not reported");
	a_data_nack: assert property (xfer_busy && data_nack && !arb_lost |=> int_n_oe)
		else $error("data nack not reported");
	a_start_busy: assert property (!xfer_busy && xfer_start && !count_bad |=> xfer_busy)
		else $error("start did not show busy");
	a_bad_count: assert property (!xfer_busy && count_bad |=> int_n_oe && !xfer_busy)
		else $error("bad count not reported");
	a_timeout_irq: assert property (timeout_abort |-> ##[0:1] (int_n_oe && !xfer_busy))
		else $error("time-out not reported");
	a_restart_free: assert property (restart_req |-> $past(bus_free))
		else $error("restart on a taken bus");
	// any divider, even 0 or 1, still leaves 27 clocks or more between quarters
	a_scl_spacing: assert property (scl_quarter_tick |=> !scl_quarter_tick [*8])
		else $error("quarter ticks too close");
endmodule : bridge_status_regs_checker

bind bridge_status_regs bridge_status_regs_checker chk
(
	.clk, .nrst, .cmd_valid, .cmd_code, .cmd_addr, .cmd_wdata, .rd_valid, .prog_pin_mode,
	.pin_out, .pin_oe, .xfer_start, .xfer_ok, .addr_nack, .data_nack, .arb_lost, .bus_free,
	.count_bad, .own_addr, .scl_quarter_tick, .xfer_busy, .restart_req, .timeout_abort, .int_n_oe
);

// File: verif/i2c_engine_model.sv
// behavioural stand-in for the i2c master engine and the slaves behind it
`timescale 1ns/1ps

module i2c_engine_model
(
	input  wire logic clk,
	input  wire logic restart_req,
	output logic      xfer_start,
	output logic      xfer_ok,
	output logic      addr_nack,
	output logic      data_nack,
	output logic      arb_lost,
	output logic      bus_free,
	output logic      count_bad
);
	logic restart_seen = 1'b0;

	// quiet idle bus until a test asks for an event
	initial
	begin
		{xfer_start, xfer_ok, addr_nack, data_nack, arb_lost, count_bad} = '0;
		bus_free = 1'b1;
	end

	// one-cycle event: 0 ok, 1 addr nack, 2 data nack, 3 lost, 4 bad count, else start
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: xfer_ok <= 1'b1;
			1: addr_nack <= 1'b1;
			2: data_nack <= 1'b1;
			3: {arb_lost, bus_free} <= 2'b10;
			4: count_bad <= 1'b1;
			default: xfer_start <= 1'b1;
		endcase
		@(posedge clk);
		{xfer_start, xfer_ok, addr_nack, data_nack, arb_lost, count_bad} <= '0;
	endtask : pulse

	// the winner keeps the bus for hold cycles; the retry is awaited a bounded time
	task automatic lose(input int hold);
		int i;
		pulse(3);
		repeat (hold) @(posedge clk);
		bus_free <= 1'b1;
		restart_seen = 1'b0;
		for (i = 0; i < 8 && !restart_seen; i++)
		begin
			@(posedge clk);
			#1 restart_seen = restart_req;
		end
		pulse(0);
	endtask : lose
endmodule : i2c_engine_model

// File: verif/bridge_status_regs_tb_top.sv
// self-checking bench for the bridge status register block
`timescale 1ns/1ps

module bridge_status_regs_tb_top;
	logic       clk           = 1'b0;
	logic       nrst          = 1'b0;
	logic       cmd_valid     = 1'b0;
	logic [7:0] cmd_code      = 8'h00;
	logic [7:0] cmd_addr      = 8'h00;
	logic [7:0] cmd_wdata     = 8'h00;
	logic [7:0] prog_pin_mode = 8'h00;
	logic [5:0] pin_in        = 6'h3F;
	logic [7:0] rd_data;
	logic [7:0] rd;
	logic [6:0] own_addr;
	logic [5:0] pin_out;
	logic [5:0] pin_oe;
	logic       rd_valid, xfer_start, xfer_ok, addr_nack, data_nack, arb_lost, bus_free;
	logic       count_bad, scl_quarter_tick, scl_phase_high, xfer_busy, restart_req;
	logic       timeout_abort, int_n_out, int_n_oe;
	int         errors          = 0;
	int         samples_checked = 0;
	int         cycles          = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	bridge_status_regs dut (.clk, .nrst, .cmd_valid, .cmd_code, .cmd_addr, .cmd_wdata,
		.rd_valid, .rd_data, .prog_pin_mode, .pin_in, .pin_out, .pin_oe, .xfer_start,
		.xfer_ok, .addr_nack, .data_nack, .arb_lost, .bus_free, .count_bad, .own_addr,
		.scl_quarter_tick, .scl_phase_high, .xfer_busy, .restart_req, .timeout_abort,
		.int_n_out, .int_n_oe);
	i2c_engine_model eng (.clk, .restart_req, .xfer_start, .xfer_ok, .addr_nack,
		.data_nack, .arb_lost, .bus_free, .count_bad);

	// hang guard: the run needs about five thousand cycles, most of them in the timer test
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			stop_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one parsed command, held for exactly one taking edge
	task automatic reg_op(input logic [7:0] code, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code  <= code;
		cmd_addr  <= addr;
		cmd_wdata <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1 rd = rd_data;
		chk({7'h00, rd_valid}, {7'h00, code == 8'h21});
	endtask : reg_op

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		reg_op(8'h21, addr, 8'h00);
		chk(rd, exp);
	endtask : rd_chk

	task automatic t_reset;
		chk({7'h00, int_n_oe}, 8'h00);
		rd_chk(8'h02, 8'h19);
		rd_chk(8'h03, 8'hFE);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h04, 8'hF0);
		$display("test reset_values done");
	endtask : t_reset

	// readback, a read-only write, an unmapped read and an unknown command
	task automatic t_regs;
		reg_op(8'h20, 8'h02, 8'h05);
		rd_chk(8'h02, 8'h05);
		reg_op(8'h20, 8'h03, 8'h00);
		rd_chk(8'h03, 8'h00);
		reg_op(8'h20, 8'h05, 8'hA5);
		rd_chk(8'h05, 8'hA4);
		chk({1'b0, own_addr}, 8'h52);
		reg_op(8'h20, 8'h05, 8'h24);
		rd_chk(8'h05, 8'h24);
		reg_op(8'h20, 8'h04, 8'h00);
		rd_chk(8'h04, 8'hF0);
		rd_chk(8'h07, 8'h00);
		reg_op(8'h22, 8'h02, 8'h00);
		$display("test register_access done");
	endtask : t_regs

	// live pin levels differ from the written latch on purpose
	task automatic t_pins;
		@(posedge clk);
		prog_pin_mode <= 8'hAA;
		pin_in        <= 6'h2A;
		reg_op(8'h20, 8'h01, 8'hF5);
		chk({2'b00, pin_out}, 8'h05);
		chk({2'b00, pin_oe}, 8'h0F);
		rd_chk(8'h01, 8'h2A);
		// mixed modes: pin0 input, pin1 open drain, pin2 quasi, pin3 push-pull
		@(posedge clk);
		prog_pin_mode <= 8'h8D;
		reg_op(8'h20, 8'h01, 8'h0A);
		chk({2'b00, pin_out}, 8'h08);
		chk({2'b00, pin_oe}, 8'h3C);
		$display("test pin_state done");
	endtask : t_pins

	// completion and both nack codes after 0, 9 and 18 idle cycles; bad count comes from idle
	task automatic t_results;
		logic [7:0] codes [4] = '{8'hF0, 8'hF1, 8'hF2, 8'hF9};
		int         i;
		for (i = 0; i < 4; i++)
		begin
			if (i < 3)
			begin
				eng.pulse(5);
				#1 chk({7'h00, int_n_oe}, 8'h00);
				rd_chk(8'h04, 8'hF3);
				repeat (i * 9) @(posedge clk);
			end
			eng.pulse(i < 3 ? i : 4);
			#1 chk({7'h00, int_n_oe}, 8'h01);
			chk({7'h00, int_n_out}, 8'h00);
			rd_chk(8'h04, codes[i]);
			chk({7'h00, int_n_oe}, 8'h00);
		end
		$display("test transfer_results done");
	endtask : t_results

	task automatic t_arb;
		eng.pulse(5);
		eng.lose(40);
		#1 chk({7'h00, eng.restart_seen}, 8'h01);
		rd_chk(8'h04, 8'hF0);
		$display("test arbitration_retry done");
	endtask : t_arb

	// divider 5: one scl period is 20 ticks of 7.3728 MHz, 542.5 clocks of 5 ns
	task automatic t_scl;
		int   n;
		int   rises;
		logic last;
		n     = 0;
		rises = 0;
		last  = 1'b1;
		while (rises < 2 && n < 2000)
		begin
			@(posedge clk);
			#1;
			if (scl_phase_high && !last)
				rises++;
			if (rises == 1)
				n++;
			last = scl_phase_high;
		end
		chk({7'h00, n == 542 || n == 543}, 8'h01);
		$display("test scl_rate done");
	endtask : t_scl

	// counter loads {reload, nine ones} at start and counts down while enabled
	task automatic t_timer;
		reg_op(8'h20, 8'h03, 8'h03);
		eng.pulse(5);
		#1 chk(dut.state_reg.to_cnt[15:8], 8'h03);
		chk(dut.state_reg.to_cnt[7:0], 8'hFF);
		// a 57.6 kHz tick comes at most every 3473 clocks
		repeat (3600) @(posedge clk);
		#1 chk({7'h00, dut.state_reg.to_cnt < 16'h03FF}, 8'h01);
		eng.pulse(0);
		rd_chk(8'h04, 8'hF0);
		$display("test timeout_count done");
	endtask : t_timer

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// reset for six cycles, then every scenario in turn
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_scl();
		t_pins();
		t_results();
		t_arb();
		t_timer();
		stop_test();
	end
endmodule : bridge_status_regs_tb_top
